// file: hdl/sebf_device.sv
// memory-side front end of the two-wire bus
//
// Behaviour
// - data changes with clock high are conditions
// - data fall, clock high: start condition
// - data rise, clock high: stop ends transfer
// - stop after read enters standby
// - 8-bit words, receiver acknowledges on ninth clock
// - standby at power-up and after completion
// - start, nine clocks, start, stop recovers
// - address word top nibble matches type code
// - bits 3..1 compare with address straps
// - floating strap reads as zero
// - six/four-ball variants fix lower straps zero
// - five-ball variant expects 001 straps
// - bit 0 one reads, zero writes
// - match acknowledges, mismatch returns to standby
// - write-protect high inhibits writes, not four-ball
// - write cycle at stop, within 5 ms
// - sample on rising, change after falling
// - only pull data low or release
// - ignore bus during write cycle
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module sebf_device #(
    parameter int unsigned WR_CYCLES = sebf_pkg::TWR_CYC
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // two-wire bus
    sebf_if.dev               bus,
    // package and straps
    input  wire logic [1:0]   pkg_variant,
    input  wire logic         addr_strap_high,
    input  wire logic         addr_strap_mid,
    input  wire logic         addr_strap_low,
    input  wire logic         write_protect,
    // data to and from the memory core
    input  wire logic [7:0]   rd_data,
    output logic              rd_req,
    output logic [7:0]        rx_data,
    output logic              rx_valid,
    // status
    output logic              op_read,
    output logic              standby,
    output logic              write_busy
);
    import sebf_pkg::*;

    typedef struct packed {
        sebf_dstate_e st;
        logic [7:0]   sh;
        logic [3:0]   cnt;
        logic         rw;
        logic         drv;
        logic         mack;
        logic [1:0]   bcnt;
        logic [19:0]  wtim;
        logic         wbusy;
        logic         scl_q;
        logic         sda_q;
        logic [3:0]   pin1;
        logic [3:0]   pin2;
        logic [7:0]   rx;
        logic         rx_v;
        logic         rd_r;
    } sebf_dev_s;

    sebf_dev_s r;
    sebf_dev_s next_r;
    logic      scl_f;
    logic      sda_f;
    logic      start_c;
    logic      stop_c;
    logic      rise;
    logic      fall;
    logic      wp_eff;

    // ------------------------------------------------------------
    // input conditioning
    // ------------------------------------------------------------
    sebf_filter u_scl_filter (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (bus.scl),
        .level   (scl_f)
    );

    sebf_filter u_sda_filter (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (bus.sda),
        .level   (sda_f)
    );

    // expected strap field for the fitted package
    function automatic logic [2:0] strap_expect(input logic [1:0] v, input logic [2:0] s);
        logic [2:0] e;
        e = s;
        if (v == PKG_SIX) begin
            e = {s[2], 2'b00};
        end else if (v == PKG_FIVE) begin
            e = FIVE_STRAPS;
        end else if (v == PKG_FOUR) begin
            e = 3'b000;
        end
        return e;
    endfunction

    // address word check: type code, straps, direction bit ignored
    function automatic logic addr_match(input logic [7:0] w, input logic [1:0] v,
                                        input logic [2:0] s);
        return (w[7:4] == TYPE_CODE) && (w[3:1] == strap_expect(v, s));
    endfunction

    // ------------------------------------------------------------
    // bus conditions
    // ------------------------------------------------------------
    assign start_c = r.scl_q & scl_f & r.sda_q & ~sda_f;
    assign stop_c  = r.scl_q & scl_f & ~r.sda_q & sda_f;
    assign rise    = ~r.scl_q & scl_f;
    assign fall    = r.scl_q & ~scl_f;
    assign wp_eff  = r.pin2[3] & (pkg_variant != PKG_FOUR);

    // ------------------------------------------------------------
    // protocol engine
    // ------------------------------------------------------------
    always_comb begin
        next_r       = r;
        next_r.rx_v  = 1'b0;
        next_r.rd_r  = 1'b0;
        next_r.scl_q = scl_f;
        next_r.sda_q = sda_f;
        // an undriven strap or protect pin reads low
        next_r.pin1  = {write_protect === 1'b1, addr_strap_high === 1'b1,
                        addr_strap_mid === 1'b1, addr_strap_low === 1'b1};
        next_r.pin2  = r.pin1;
        if (r.wbusy) begin
            next_r.st  = D_IDLE;
            next_r.drv = 1'b0;
            if (r.wtim == 20'(WR_CYCLES - 1)) begin
                next_r.wbusy = 1'b0;
            end else begin
                next_r.wtim = r.wtim + 20'h1;
            end
        end else if (start_c) begin
            next_r.st   = D_ADDR;
            next_r.cnt  = 4'h0;
            next_r.drv  = 1'b0;
            next_r.bcnt = 2'h0;
        end else if (stop_c) begin
            next_r.st  = D_IDLE;
            next_r.drv = 1'b0;
            if (!r.rw && r.bcnt == 2'h3 && !wp_eff) begin
                next_r.wbusy = 1'b1;
                next_r.wtim  = 20'h0;
            end
        end else if (r.st != D_IDLE) begin
            if (rise) begin
                next_r.cnt = r.cnt + 4'h1;
                if (r.st != D_RDATA && r.cnt < 4'h8) begin
                    next_r.sh = {r.sh[6:0], sda_f};
                end
                if (r.st == D_RDATA && r.cnt == 4'h8) begin
                    next_r.mack = ~sda_f;
                end
            end else if (fall) begin
                case (r.cnt)
                    4'h8: begin
                        if (r.st == D_ADDR) begin
                            if (addr_match(r.sh, pkg_variant, r.pin2[2:0])) begin
                                next_r.drv = 1'b1;
                                next_r.rw  = r.sh[0];
                            end else begin
                                next_r.st = D_IDLE;
                            end
                        end else if (r.st == D_WDATA) begin
                            next_r.drv  = 1'b1;
                            next_r.rx   = r.sh;
                            next_r.rx_v = 1'b1;
                            if (r.bcnt != 2'h3) begin
                                next_r.bcnt = r.bcnt + 2'h1;
                            end
                        end else begin
                            next_r.drv = 1'b0; // release for the controller's answer
                        end
                    end
                    4'h9: begin
                        next_r.cnt = 4'h0;
                        next_r.drv = 1'b0;
                        if ((r.st == D_ADDR && r.rw) || (r.st == D_RDATA && r.mack)) begin
                            next_r.st   = D_RDATA;
                            next_r.sh   = rd_data;
                            next_r.rd_r = 1'b1;
                            next_r.drv  = ~rd_data[7];
                        end else if (r.st == D_ADDR) begin
                            next_r.st = D_WDATA;
                        end else if (r.st == D_RDATA) begin
                            next_r.st = D_IDLE; // no answer: wait for stop
                        end
                    end
                    default: begin
                        if (r.st == D_RDATA && r.cnt != 4'h0) begin
                            next_r.drv = ~r.sh[3'(4'h7 - r.cnt)];
                        end
                    end
                endcase
            end
        end
    end

    // state register, standby at power-up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '{st: D_IDLE, sh: 8'h00, cnt: 4'h0, rw: 1'b0, drv: 1'b0, mack: 1'b0,
                   bcnt: 2'h0, wtim: 20'h0, wbusy: 1'b0, scl_q: 1'b1, sda_q: 1'b1,
                   pin1: 4'h0, pin2: 4'h0, rx: 8'h00, rx_v: 1'b0, rd_r: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign bus.sda_d_out = 1'b0;
    assign bus.sda_d_oe  = r.drv;
    assign rd_req        = r.rd_r;
    assign rx_data       = r.rx;
    assign rx_valid      = r.rx_v;
    assign op_read       = r.rw;
    assign standby       = (r.st == D_IDLE) & ~r.wbusy;
    assign write_busy    = r.wbusy;
endmodule // sebf_device
`default_nettype wire

// file: hdl/sebf_filter.sv
// pin synchroniser followed by a glitch filter
`timescale 1ns/100ps
`default_nettype none
module sebf_filter (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // pin in, clean level out
    input  wire logic pin,
    output logic      level
);
    import sebf_pkg::*;

    typedef struct packed {
        logic       s1;
        logic       s2;
        logic       flt;
        logic [2:0] cnt;
    } sebf_flt_s;

    sebf_flt_s r;
    sebf_flt_s next_r;

    // level follows only after the synchronised pin differs long enough
    always_comb begin
        next_r    = r;
        next_r.s1 = pin;
        next_r.s2 = r.s1;
        if (r.s2 == r.flt) begin
            next_r.cnt = 3'h0;
        end else if (r.cnt == FILT_CYC - 3'h1) begin
            next_r.flt = r.s2;
            next_r.cnt = 3'h0;
        end else begin
            next_r.cnt = r.cnt + 3'h1;
        end
    end

    // state register, idle bus reads high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '{s1: 1'b1, s2: 1'b1, flt: 1'b1, cnt: 3'h0};
        end else begin
            r <= next_r;
        end
    end

    assign level = r.flt;
endmodule // sebf_filter
`default_nettype wire

// file: hdl/sebf_host.sv
// bus controller end, ordered over APB
`timescale 1ns/100ps
`default_nettype none
module sebf_host (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // two-wire bus
    sebf_if.host             bus
);
    import sebf_pkg::*;

    typedef struct packed {
        logic        run;
        sebf_kind_e  kind;
        logic [3:0]  slot;
        logic [1:0]  ph;
        logic [6:0]  div;
        logic        scl_lvl;
        logic        sda_lvl;
        logic [7:0]  tx;
        logic [7:0]  rx;
        logic        ack;
        logic        nack;
        logic        s1;
        logic        s2;
        logic [31:0] rdata;
    } sebf_host_s;

    sebf_host_s r;
    sebf_host_s next_r;
    logic       mapped;
    logic [1:0] ab;
    logic [1:0] ab0;

    // data line per slot: {level for quarters 0..2, level for quarter 3}
    function automatic logic [1:0] slot_ab(input sebf_kind_e k, input logic [3:0] s,
                                           input logic [7:0] t, input logic a);
        logic [1:0] v;
        v = 2'b11;
        case (k)
            K_START: v = 2'b10;
            K_STOP:  v = 2'b01;
            K_WRITE: v = (s < 4'h8) ? {2{t[3'(4'h7 - s)]}} : 2'b11;
            K_READ:  v = (s < 4'h8) ? 2'b11 : {2{~a}};
            default: v = (s == 4'h0 || s == 4'ha) ? 2'b10 : ((s == 4'hb) ? 2'b01 : 2'b11);
        endcase
        return v;
    endfunction

    // index of the last slot of each command
    function automatic logic [3:0] last_slot(input sebf_kind_e k);
        logic [3:0] v;
        v = 4'h0;
        if (k == K_WRITE || k == K_READ) begin
            v = 4'h8;
        end else if (k == K_RECOVER) begin
            v = 4'hb;
        end
        return v;
    endfunction

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    always_comb begin
        if (paddr == REG_CMD) begin
            mapped = 1'b1;
        end else if (paddr == REG_TXD) begin
            mapped = 1'b1;
        end else if (paddr == REG_STATUS) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end

    assign ab  = slot_ab(r.kind, r.slot, r.tx, r.ack);
    assign ab0 = slot_ab(r.kind, r.slot + 4'h1, r.tx, r.ack);

    // ------------------------------------------------------------
    // register access and bus sequencer
    // ------------------------------------------------------------
    always_comb begin
        logic [1:0] first_ab;
        first_ab  = 2'b11;
        next_r    = r;
        next_r.s1 = bus.sda;
        next_r.s2 = r.s1;
        // read data is latched in the setup cycle
        if (psel && !penable) begin
            next_r.rdata = 32'h0;
            if (paddr == REG_TXD) begin
                next_r.rdata = {24'h0, r.tx};
            end else if (paddr == REG_STATUS) begin
                next_r.rdata = {16'h0, r.rx, 6'h0, r.nack, r.run};
            end
        end
        if (psel && penable && pwrite && !r.run) begin
            if (paddr == REG_TXD) begin
                next_r.tx = pwdata[7:0];
            end else if (paddr == REG_CMD && pwdata[4:0] != 5'h0) begin
                next_r.run  = 1'b1;
                next_r.slot = 4'h0;
                next_r.ph   = 2'h0;
                next_r.div  = 7'h0;
                next_r.ack  = pwdata[CMD_ACK];
                next_r.scl_lvl = 1'b0;
                if (pwdata[CMD_START]) begin
                    next_r.kind = K_START;
                end else if (pwdata[CMD_WRITE]) begin
                    next_r.kind = K_WRITE;
                end else if (pwdata[CMD_READ]) begin
                    next_r.kind = K_READ;
                end else if (pwdata[CMD_STOP]) begin
                    next_r.kind = K_STOP;
                end else begin
                    next_r.kind = K_RECOVER;
                end
                first_ab       = slot_ab(next_r.kind, 4'h0, next_r.tx, next_r.ack);
                next_r.sda_lvl = first_ab[1];
            end
        end
        if (r.run) begin
            if (r.div == QTR_CYC - 7'h1) begin
                next_r.div = 7'h0;
                next_r.ph  = r.ph + 2'h1;
                if (r.ph == 2'h1) begin
                    next_r.scl_lvl = 1'b1;
                end else if (r.ph == 2'h2) begin
                    next_r.sda_lvl = ab[0];
                    if (r.kind == K_WRITE && r.slot == 4'h8) begin
                        next_r.nack = r.s2;
                    end else if (r.kind == K_READ && r.slot < 4'h8) begin
                        next_r.rx = {r.rx[6:0], r.s2};
                    end
                end else if (r.ph == 2'h3) begin
                    if (r.slot == last_slot(r.kind)) begin
                        next_r.run = 1'b0; // clock left high
                        next_r.ph  = 2'h3;
                    end else begin
                        next_r.slot    = r.slot + 4'h1;
                        next_r.scl_lvl = 1'b0;
                        next_r.sda_lvl = ab0[1];
                    end
                end
            end else begin
                next_r.div = r.div + 7'h1;
            end
        end
    end

    // state register, bus released at reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '{run: 1'b0, kind: K_START, slot: 4'h0, ph: 2'h0, div: 7'h0,
                   scl_lvl: 1'b1, sda_lvl: 1'b1, tx: 8'h00, rx: 8'h00, ack: 1'b0,
                   nack: 1'b0, s1: 1'b1, s2: 1'b1, rdata: 32'h0};
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign prdata        = r.rdata;
    assign pready        = 1'b1;
    assign pslverr       = psel & penable & ~mapped;
    assign bus.scl_out   = 1'b0;
    assign bus.scl_oe    = ~r.scl_lvl;
    assign bus.sda_h_out = 1'b0;
    assign bus.sda_h_oe  = ~r.sda_lvl;
endmodule // sebf_host
`default_nettype wire

// file: pkg/sebf_if.sv
// open-drain two-wire bus joining controller and memory front end
`timescale 1ns/100ps
`default_nettype none
interface sebf_if;
    logic scl_out;
    logic scl_oe;
    logic sda_h_out;
    logic sda_h_oe;
    logic sda_d_out;
    logic sda_d_oe;
    logic scl;
    logic sda;

    // wired-and with pull-up: a driver only counts while pulling low
    assign scl = ~(scl_oe & ~scl_out);
    assign sda = ~((sda_h_oe & ~sda_h_out) | (sda_d_oe & ~sda_d_out));

    modport host (output scl_out, output scl_oe, output sda_h_out, output sda_h_oe,
                  input scl, input sda);
    modport dev  (input scl, input sda, output sda_d_out, output sda_d_oe);
endinterface // sebf_if
`default_nettype wire

// file: pkg/sebf_pkg.sv
// shared constants and types of the two-wire memory bus front end
`default_nettype none
package sebf_pkg;
    // ----------------------------------------------------------------
    // clock and timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ  = 125;
    localparam int CLK_KHZ  = 125000;
    localparam int TWR_MS   = 5;                            // self_timed_write_duration
    localparam int TWR_CYC  = TWR_MS * CLK_KHZ;             // longest time, rounds down
    localparam int NOISE_NS = 50;                           // glitch suppression window
    localparam logic [2:0] FILT_CYC = 3'(NOISE_NS * CLK_MHZ / 1000);
    localparam int QTR_NS   = 625;                          // quarter of a bus clock period
    localparam logic [6:0] QTR_CYC = 7'((QTR_NS * CLK_MHZ + 999) / 1000);

    // ----------------------------------------------------------------
    // device addressing
    // ----------------------------------------------------------------
    localparam logic [3:0] TYPE_CODE = 4'h6;                // arbitrary value
    localparam logic [1:0] PKG_FULL  = 2'h0;                // all three straps
    localparam logic [1:0] PKG_SIX   = 2'h1;                // top strap only
    localparam logic [1:0] PKG_FIVE  = 2'h2;                // straps fixed 001
    localparam logic [1:0] PKG_FOUR  = 2'h3;                // straps fixed 000
    localparam logic [2:0] FIVE_STRAPS = 3'h1;

    // ----------------------------------------------------------------
    // controller registers
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_CMD    = 8'h00;
    localparam logic [7:0] REG_TXD    = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam int CMD_START   = 0;
    localparam int CMD_STOP    = 1;
    localparam int CMD_WRITE   = 2;
    localparam int CMD_READ    = 3;
    localparam int CMD_RECOVER = 4;
    localparam int CMD_ACK     = 8;
    localparam int ST_BUSY     = 0;
    localparam int ST_NACK     = 1;
    localparam int ST_RX_LSB   = 8;

    // ----------------------------------------------------------------
    // state and command encodings
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        D_IDLE  = 2'h0,
        D_ADDR  = 2'h1,
        D_WDATA = 2'h3,
        D_RDATA = 2'h2
    } sebf_dstate_e;

    typedef enum logic [2:0] {
        K_START   = 3'h0,
        K_STOP    = 3'h1,
        K_WRITE   = 3'h3,
        K_READ    = 3'h2,
        K_RECOVER = 3'h6
    } sebf_kind_e;
endpackage
`default_nettype wire

// file: verif/sebf_chk.sv
// wire-level checker for the two-wire bus
`timescale 1ns/100ps
`default_nettype none
module sebf_chk (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bus signals
    input wire logic sda_d_out,
    input wire logic sda_d_oe,
    input wire logic scl,
    input wire logic sda
);
    logic       p_scl;
    logic       p_sda;
    logic [3:0] bits;
    logic [2:0] nb;
    logic       start_c;
    logic       stop_c;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // conditions seen on the resolved lines
    assign start_c = scl & p_scl & p_sda & ~sda;
    assign stop_c  = scl & p_scl & ~p_sda & sda;

    // clock rises and words since the last start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p_scl <= 1'b1;
            p_sda <= 1'b1;
            bits  <= 4'h0;
            nb    <= 3'h0;
        end else begin
            p_scl <= scl;
            p_sda <= sda;
            if (start_c) begin
                bits <= 4'h0;
                nb   <= 3'h0;
            end else if (scl & ~p_scl) begin
                bits <= (bits == 4'h8) ? 4'h0 : bits + 4'h1;
                nb   <= (bits == 4'h8) ? nb + 3'h1 : nb;
            end
        end
    end

    // device stays off the line for a while
    sequence s_quiet;
        !sda_d_oe [*8];
    endsequence

    a_dev_pull_only: assert property (sda_d_oe |-> !sda_d_out)
        else $error("device drives data high");
    a_chg_clk_low: assert property ($changed(sda_d_oe) |-> !scl)
        else $error("device data moved with clock high");
    a_chg_after_fall: assert property ($changed(sda_d_oe) |-> !$past(scl, 4))
        else $error("device data moved too soon after clock edge");
    a_addr_no_drive: assert property (nb == 3'h0 && bits < 4'h8 |-> !sda_d_oe)
        else $error("device drives during address bits");
    a_ack_ninth: assert property ($rose(sda_d_oe) && nb == 3'h0 |-> bits == 4'h8)
        else $error("address acknowledge off the ninth clock");
    a_ack_hold: assert property ($rose(sda_d_oe) && nb == 3'h0 |=> sda_d_oe [*8])
        else $error("acknowledge not held");
    a_stop_quiet: assert property (stop_c |=> s_quiet)
        else $error("device drives after stop");
    a_start_quiet: assert property (start_c |=> s_quiet)
        else $error("device drives after start");
endmodule // sebf_chk
`default_nettype wire

// file: verif/tb_serial_eeprom_bus_front_end.sv
// self-checking bench: controller and memory front end back to back
`timescale 1ns/100ps
`default_nettype none
module tb_serial_eeprom_bus_front_end;
    import sebf_pkg::*;
    localparam int unsigned WRC = 5000;
    localparam logic [31:0] C_STA = 32'h1, C_STO = 32'h2, C_WR = 32'h4, C_RD = 32'h8;
    localparam logic [31:0] C_REC = 32'h10;
    localparam logic [7:0] GA [4] = '{{TYPE_CODE, 4'ha}, {TYPE_CODE, 4'h8},
                                      {TYPE_CODE, 4'h2}, {TYPE_CODE, 4'h0}};
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, rd_data = 8'h00, rx_data;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [1:0] pkg_variant = 2'h0;
    logic addr_strap_high = 1'b1, addr_strap_mid = 1'bz, addr_strap_low = 1'b1;
    logic write_protect = 1'b0, pready, pslverr, err;
    logic rd_req, rx_valid, op_read, standby, write_busy;
    int n_errors = 0, num_checks = 0, i;
    int n_rxv = 0, n_rdq = 0;

    sebf_if sebf_if_i ();
    sebf_host sebf_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus(sebf_if_i.host));
    sebf_device #(.WR_CYCLES(WRC)) sebf_device_i (.pclk(pclk), .presetn(presetn),
        .bus(sebf_if_i.dev), .pkg_variant(pkg_variant), .addr_strap_high(addr_strap_high),
        .addr_strap_mid(addr_strap_mid), .addr_strap_low(addr_strap_low),
        .write_protect(write_protect), .rd_data(rd_data), .rd_req(rd_req), .rx_data(rx_data),
        .rx_valid(rx_valid), .op_read(op_read), .standby(standby), .write_busy(write_busy));
    sebf_chk sebf_chk_i (.pclk(pclk), .presetn(presetn), .sda_d_out(sebf_if_i.sda_d_out),
        .sda_d_oe(sebf_if_i.sda_d_oe), .scl(sebf_if_i.scl), .sda(sebf_if_i.sda));

    // count data strobes toward the memory core
    always @(posedge pclk) begin
        if (rx_valid === 1'b1) n_rxv++;
        if (rd_req === 1'b1) n_rdq++;
    end

    // 125 MHz clock
    initial begin
        forever #4 pclk = ~pclk;
    end

    task results;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // one apb transfer, read data and error kept in rd and err
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 50) begin
            n_errors++;
            results;
        end
    endtask

    // launch a command and poll busy, bounded
    task cmd(input logic [31:0] c);
        int k;
        apb(1'b1, REG_CMD, c);
        for (k = 0; k < 4000; k++) begin
            apb(1'b0, REG_STATUS, 32'h0);
            if (rd[ST_BUSY] === 1'b0) break;
        end
        if (k == 4000) begin
            n_errors++;
            results;
        end
    endtask

    task wb(input logic [7:0] b);
        apb(1'b1, REG_TXD, {24'h0, b});
        cmd(C_WR);
    endtask

    // address probe with expected acknowledge, then stop
    task probe(input logic [7:0] a, input logic n);
        cmd(C_STA);
        wb(a);
        apb(1'b0, REG_STATUS, 32'h0);
        chk(32'(rd[ST_NACK]), 32'(n));
        cmd(C_STO);
    endtask

    task wseq(input logic [7:0] a, input logic [7:0] d);
        cmd(C_STA);
        wb(a);
        wb(8'h00);
        wb(8'h01);
        wb(d);
        cmd(C_STO);
    endtask

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (12) @(posedge pclk);
        chk(32'(standby), 32'h1);
        chk(32'(write_busy), 32'h0);
        apb(1'b0, 8'h0c, 32'h0);
        chk(32'(err), 32'h1);
        chk(rd, 32'h0);
        // every package variant, matching and off-by-one-strap address
        for (int v = 0; v < 4; v++) begin
            pkg_variant <= 2'(v);
            probe(GA[v], 1'b0);
            probe(GA[v] ^ 8'h04, 1'b1);
            chk(32'(standby), 32'h1);
        end
        $display("test addressing done");
        write_protect <= 1'b1;
        pkg_variant <= 2'h0;
        wseq(GA[0], 8'h5a);
        chk(32'(rx_data), 32'h5a);
        chk(32'(write_busy), 32'h0);
        pkg_variant <= 2'h3;
        wseq(GA[3], 8'ha5);
        chk(32'(write_busy), 32'h1);
        chk(32'(standby), 32'h0);
        probe(GA[3], 1'b1);
        for (i = 0; i < WRC && write_busy === 1'b1; i++) @(posedge pclk);
        chk(32'(write_busy), 32'h0);
        chk(32'(standby), 32'h1);
        chk(32'(n_rxv), 32'h6);
        $display("test write cycle done");
        pkg_variant <= 2'h0;
        write_protect <= 1'b0;
        rd_data <= 8'hc3;
        cmd(C_STA);
        wb(GA[0] | 8'h01);
        chk(32'(op_read), 32'h1);
        cmd(C_RD);
        apb(1'b0, REG_STATUS, 32'h0);
        chk(32'(rd[ST_RX_LSB +: 8]), 32'hc3);
        chk(32'(n_rdq), 32'h1);
        cmd(C_STO);
        chk(32'(standby), 32'h1);
        $display("test read done");
        cmd(C_STA);
        wb(GA[0]);
        cmd(C_REC);
        probe(GA[0], 1'b0);
        $display("test recovery done");
        results;
    end
endmodule // tb_serial_eeprom_bus_front_end
`default_nettype wire
